//--- logic/adss_cfg.svh
`ifndef ADSS_CFG_SVH
`define ADSS_CFG_SVH
// Register offsets on the plain register port.
`define ADSS_OFF_CONFIG 4'h0
`define ADSS_OFF_RESULT 4'h1
`define ADSS_OFF_IRQ_STATUS 4'h2
`define ADSS_OFF_IRQ_MASK 4'h3
`define ADSS_OFF_SAMPLE 4'h4
// Configuration field positions.
`define ADSS_POS_START 15
`define ADSS_POS_INSEL 12
`define ADSS_POS_FSR 9
`define ADSS_POS_MODE 8
`define ADSS_POS_RATE 5
// Reset values.
`define ADSS_RST_INSEL 3'h0
`define ADSS_RST_FSR 3'h2
`define ADSS_RST_MODE 1'h1
`define ADSS_RST_RATE 3'h4
`define ADSS_RST_LOW 5'h03
`define ADSS_RST_RESULT 16'h0000
// Core clock in Hz.
`define ADSS_CLK_HZ 10000000
// Rates in samples per second per code.
`define ADSS_SPS_0 128
`define ADSS_SPS_1 250
`define ADSS_SPS_2 490
`define ADSS_SPS_3 920
`define ADSS_SPS_4 1600
`define ADSS_SPS_5 2400
`define ADSS_SPS_6 3300
`endif

//--- logic/adss_pkg.sv
package adss_pkg;
    typedef enum logic [2:0] {
        ADSS_IDLE = 3'b001,
        ADSS_CONV = 3'b010,
        ADSS_DONE = 3'b100
    } adss_state_e;
    typedef struct packed {
        logic start;
        logic [2:0] input_select;
        logic [2:0] full_scale_range;
        logic mode;
        logic [2:0] sample_rate_select;
        logic [4:0] low_bits;
    } adss_config_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } adss_bus_s;
endpackage

//--- logic/adss_sequencer.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "adss_cfg.svh"
// Functional notes
// [R1] The host waits at least one conversion period, one over the sample rate within ten percent, before reading.
// [R2] In single-shot mode a configuration read returns the start/status bit as 1 once a result is available.
// [R3] In continuous mode the start/status bit always reads 0.
// [R4] The host fetches a finished result by reading the conversion data register.
// [R5] Writing 1 to the start/status bit starts a new single-shot conversion on that write.
// [R6] A new start is accepted before the last result is read and the last result stays readable.
// [R7] The host waits about 50 microseconds after power-up before any transaction.
// [R8] Input-select codes 100 and 101 give single-ended measurements against ground.
// [R9] Rate codes 000 to 110 select 128 to 3300 samples per second, 111 also 3300, reset value 100.
// [R10] The mode bit selects continuous when 0 and single-shot or power-down when 1, the reset default.
// [R11] While converting in single-shot mode the status bit reads 0, and the block powers down after storing.
module adss_sequencer #(
    parameter int unsigned CLK_HZ = `ADSS_CLK_HZ
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire adss_pkg::adss_bus_s bus,
    output logic [15:0] rdata,
    input wire logic [15:0] sample_data,
    output logic sample_take,
    output logic single_ended,
    output logic conv_active,
    output logic irq
);
    import adss_pkg::*;

    // One conversion period in cycles for a rate code; the quotient rounds down, so it never runs long.
    function automatic logic [16:0] period_cycles(input logic [2:0] code);
        int unsigned sps;
        sps = `ADSS_SPS_6;
        case (code)
            3'h0: sps = `ADSS_SPS_0;
            3'h1: sps = `ADSS_SPS_1;
            3'h2: sps = `ADSS_SPS_2;
            3'h3: sps = `ADSS_SPS_3;
            3'h4: sps = `ADSS_SPS_4;
            3'h5: sps = `ADSS_SPS_5;
            default: sps = `ADSS_SPS_6;
        endcase
        return 17'(CLK_HZ / sps);
    endfunction

    adss_config_s cfg_q, cfg_d;
    adss_state_e state_q, state_d;
    logic [16:0] cnt_q, cnt_d;
    logic [15:0] result_q, result_d;
    logic ready_q, ready_d;
    logic [1:0] ists_q, ists_d;
    logic [1:0] imask_q, imask_d;
    logic [15:0] rdata_q, rdata_d;
    logic wr_cfg, start_req, conv_end;

    assign wr_cfg = bus.wr && (bus.addr == `ADSS_OFF_CONFIG);
    // A start is a write of 1 to the start/status bit in single-shot mode, also while a result is unread.
    assign start_req = wr_cfg && bus.wdata[`ADSS_POS_START] && bus.wdata[`ADSS_POS_MODE]; // [R5] [R6]
    assign conv_end = (state_q == ADSS_CONV) && (cnt_q == 17'h0_0001);

    // Conversion sequencing: idle is power-down; continuous mode restarts after one done and one idle cycle.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sample_take = 1'b0;
        if (start_req) begin
            state_d = ADSS_CONV; // [R5]
            cnt_d = period_cycles(bus.wdata[`ADSS_POS_RATE +: 3]); // [R9]
        end else begin
            case (state_q)
                ADSS_IDLE: begin
                    if (!cfg_q.mode) begin
                        state_d = ADSS_CONV; // [R10]
                        cnt_d = period_cycles(cfg_q.sample_rate_select);
                    end
                end
                ADSS_CONV: begin
                    if (conv_end) begin
                        sample_take = 1'b1;
                        state_d = ADSS_DONE;
                    end else begin
                        cnt_d = cnt_q - 17'h0_0001;
                    end
                end
                ADSS_DONE: begin
                    state_d = ADSS_IDLE; // [R11]
                end
                default: begin
                    state_d = ADSS_IDLE;
                end
            endcase
        end
    end

    // Configuration, result and ready flag; a start clears ready, the old result stays.
    always_comb begin
        cfg_d = cfg_q;
        result_d = result_q;
        ready_d = ready_q;
        if (wr_cfg) begin
            cfg_d = adss_config_s'(bus.wdata);
            cfg_d.start = 1'b0;
        end
        if (sample_take) begin
            result_d = sample_data; // [R6]
        end
        if (start_req) begin
            ready_d = 1'b0; // [R11]
        end else if (sample_take) begin
            ready_d = 1'b1; // [R2]
        end
    end

    // Sticky status: bit 0 conversion done, bit 1 start while busy; set beats clear.
    always_comb begin
        ists_d = ists_q;
        imask_d = imask_q;
        if (bus.wr && bus.addr == `ADSS_OFF_IRQ_STATUS) begin
            ists_d = ists_q & ~bus.wdata[1:0];
        end
        if (bus.wr && bus.addr == `ADSS_OFF_IRQ_MASK) begin
            imask_d = bus.wdata[1:0];
        end
        ists_d = ists_d | {start_req && (state_q == ADSS_CONV), sample_take};
    end

    // Read mux; the start/status bit only reports completion in single-shot mode.
    always_comb begin
        rdata_d = 16'h0000;
        if (bus.rd) begin
            case (bus.addr)
                `ADSS_OFF_CONFIG: begin
                    rdata_d = cfg_q;
                    rdata_d[`ADSS_POS_START] = cfg_q.mode && ready_q && (state_q != ADSS_CONV); // [R2] [R3] [R11]
                end
                `ADSS_OFF_RESULT: rdata_d = result_q; // [R4]
                `ADSS_OFF_IRQ_STATUS: rdata_d = {14'h0000, ists_q};
                `ADSS_OFF_IRQ_MASK: rdata_d = {14'h0000, imask_q};
                `ADSS_OFF_SAMPLE: rdata_d = {13'h0000, state_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // All state registers; reset lands in power-down with the documented configuration.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ADSS_IDLE;
            cnt_q <= 17'h0_0000;
            cfg_q <= {1'b0, `ADSS_RST_INSEL, `ADSS_RST_FSR, `ADSS_RST_MODE,
                      `ADSS_RST_RATE, `ADSS_RST_LOW}; // [R9] [R10]
            result_q <= `ADSS_RST_RESULT;
            ready_q <= 1'b0;
            ists_q <= 2'h0;
            imask_q <= 2'h0;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cfg_q <= cfg_d;
            result_q <= result_d;
            ready_q <= ready_d;
            ists_q <= ists_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    // Codes 100 and 101 measure the first two inputs against ground.
    assign single_ended = (cfg_q.input_select == 3'h4) || (cfg_q.input_select == 3'h5); // [R8]
    assign conv_active = (state_q == ADSS_CONV);
    assign irq = |(ists_q & imask_q);

    // Checks on what the sequencer drives; all run on the core clock, and all but the two reset checks sleep during reset.

    // A single-shot start enters conversion and withdraws the ready flag.
    chk_start_loads: assert property (@(posedge core_clk) disable iff (srst) // [R5]
        start_req |=> state_q == ADSS_CONV && !ready_q)
        else $error("start did not begin conversion");

    // Continuous mode never reports completion through the status bit.
    chk_cont_status_zero: assert property (@(posedge core_clk) disable iff (srst) // [R3]
        bus.rd && bus.addr == `ADSS_OFF_CONFIG && !cfg_q.mode |=> !rdata[`ADSS_POS_START])
        else $error("status bit set in continuous mode");

    // A stored result in single-shot mode reads back as a set status bit.
    chk_done_status_one: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        bus.rd && bus.addr == `ADSS_OFF_CONFIG && cfg_q.mode && ready_q
        && state_q != ADSS_CONV |=> rdata[`ADSS_POS_START])
        else $error("status bit not reported");

    // A read during conversion shows the status bit low.
    chk_busy_status_zero: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        bus.rd && bus.addr == `ADSS_OFF_CONFIG && state_q == ADSS_CONV |=> !rdata[`ADSS_POS_START])
        else $error("status bit set while busy");

    // The result only moves on a capture, so an unread result survives a restart.
    chk_result_kept: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        !sample_take |=> $stable(result_q))
        else $error("result changed without a sample");

    // After storing, the block drops back to power-down unless restarted.
    chk_done_powerdown: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        sample_take && !start_req ##1 !start_req |=> state_q == ADSS_IDLE)
        else $error("no power-down after store");

    // A result read returns the stored word one cycle later.
    chk_result_read: assert property (@(posedge core_clk) disable iff (srst) // [R4]
        bus.rd && bus.addr == `ADSS_OFF_RESULT |=> rdata == $past(result_q))
        else $error("result read wrong");

    // Only codes 100 and 101 select a ground-referenced measurement.
    chk_single_ended: assert property (@(posedge core_clk) disable iff (srst) // [R8]
        single_ended == (cfg_q.input_select[2:1] == 2'b10))
        else $error("single-ended decode wrong");

    // Continuous mode leaves power-down on its own after one idle cycle.
    chk_cont_restart: assert property (@(posedge core_clk) disable iff (srst) // [R10]
        state_q == ADSS_IDLE && !cfg_q.mode && !start_req |=> state_q == ADSS_CONV)
        else $error("continuous mode stalled");

    // The capture strobe is a single pulse.
    chk_take_one_cycle: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        sample_take |=> !sample_take)
        else $error("capture strobe too long");

    // A capture makes the result available.
    chk_take_sets_ready: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        sample_take |=> ready_q)
        else $error("ready not set after capture");

    // The word captured is the converter word of the capture cycle.
    chk_take_stores: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        sample_take |=> result_q == $past(sample_data))
        else $error("captured word wrong");

    // A start leaves the previous result untouched.
    chk_start_keeps_result: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        start_req |=> result_q == $past(result_q))
        else $error("start disturbed the result");

    // Reset restores the default rate code; no disable here, reset is the trigger.
    chk_rate_reset: assert property (@(posedge core_clk) // [R9]
        srst |=> cfg_q.sample_rate_select == `ADSS_RST_RATE)
        else $error("rate code wrong after reset");

    // Reset restores single-shot and power-down.
    chk_mode_reset: assert property (@(posedge core_clk) // [R10]
        srst |=> cfg_q.mode == `ADSS_RST_MODE)
        else $error("mode wrong after reset");

    // Single-shot power-down holds until a start arrives.
    chk_idle_holds: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        state_q == ADSS_IDLE && cfg_q.mode && !start_req |=> state_q == ADSS_IDLE)
        else $error("left power-down without a start");

    // The state register never holds an illegal code.
    chk_state_onehot: assert property (@(posedge core_clk) disable iff (srst) // [R11]
        $onehot(state_q))
        else $error("state code not one-hot");

    // The start bit is a strobe and is never kept in the configuration.
    chk_start_bit_low: assert property (@(posedge core_clk) disable iff (srst) // [R5]
        wr_cfg |=> !cfg_q.start)
        else $error("start bit stored");

    // A restart during a conversion is accepted and flagged.
    chk_busy_flag: assert property (@(posedge core_clk) disable iff (srst) // [R6]
        start_req && state_q == ADSS_CONV |=> ists_q[1] && state_q == ADSS_CONV)
        else $error("restart while busy not flagged");

    // Read data are zero outside the cycle after a read strobe.
    chk_rdata_idle: assert property (@(posedge core_clk) disable iff (srst) // [R4]
        !bus.rd |=> rdata == 16'h0000)
        else $error("read data outside a read");

    // A configuration read returns the stored fields below the status bit.
    chk_cfg_readback: assert property (@(posedge core_clk) disable iff (srst) // [R10]
        bus.rd && bus.addr == `ADSS_OFF_CONFIG |=> rdata[14:0] == $past(cfg_q[14:0]))
        else $error("configuration readback wrong");

    // An unmasked completion raises the interrupt.
    chk_done_irq: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        sample_take && imask_q[0] |=> irq)
        else $error("completion interrupt missing");

    // Clearing both status bits with no new event drops the interrupt.
    chk_irq_clear: assert property (@(posedge core_clk) disable iff (srst) // [R2]
        bus.wr && bus.addr == `ADSS_OFF_IRQ_STATUS && bus.wdata[1:0] == 2'h3
        && !sample_take && !start_req |=> !irq)
        else $error("interrupt stayed after clear");

    // The period counter steps down by one each converting cycle but the last, unless a start reloads it.
    chk_conv_counting: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        state_q == ADSS_CONV && !conv_end && !start_req
        |=> state_q == ADSS_CONV && cnt_q == $past(cnt_q) - 17'h0_0001)
        else $error("conversion counter misstepped");

    // Code 110 loads the period of the fastest rate.
    chk_period_fast: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        start_req && bus.wdata[`ADSS_POS_RATE +: 3] == 3'h6 |=> cnt_q == 17'(CLK_HZ / `ADSS_SPS_6))
        else $error("fastest rate period wrong");

    // Code 111 aliases the fastest rate.
    chk_rate_alias: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        start_req && bus.wdata[`ADSS_POS_RATE +: 3] == 3'h7 |=> cnt_q == 17'(CLK_HZ / `ADSS_SPS_6))
        else $error("rate code 111 period wrong");

    // Code 000 loads the period of the slowest rate.
    chk_period_slow: assert property (@(posedge core_clk) disable iff (srst) // [R9]
        start_req && bus.wdata[`ADSS_POS_RATE +: 3] == 3'h0 |=> cnt_q == 17'(CLK_HZ / `ADSS_SPS_0))
        else $error("slowest rate period wrong");
endmodule

//--- testbench/adss_conv_model.sv
`timescale 1ns/100ps
// Stand-in for the converter core behind the sequencer.
// Its word moves every cycle, so a capture taken one cycle early or late shows up as a wrong result.
module adss_conv_model (
    input wire logic core_clk,
    input wire logic srst,
    output logic [15:0] sample_data
);
    logic [15:0] word_q;
    logic [15:0] word_d;
    // An odd step keeps the lowest bit toggling on every cycle.
    always_comb begin
        word_d = word_q + 16'h0b3d;
    end
    // The word restarts from a fixed seed on reset.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            word_q <= 16'h1357;
        end else begin
            word_q <= word_d;
        end
    end
    assign sample_data = word_q;
endmodule

//--- testbench/adss_sequencer_bench.sv
`timescale 1ns/100ps
`include "adss_cfg.svh"
module adss_sequencer_bench;
    import adss_pkg::*;
    localparam int unsigned HZ = 100000;
    localparam int unsigned SPS [8] = '{128, 250, 490, 920, 1600, 2400, 3300, 3300};
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    adss_bus_s bus = '0;
    logic [15:0] rdata, sample_data, cfg, exp_q[$];
    logic [15:0] last_res = 16'h0000;
    logic sample_take, single_ended, conv_active, irq;
    logic pend = 1'b0;
    logic [31:0] lfsr_q = 32'h8630;
    int errors = 0, compares = 0, cyc = 0, conv_len = 0;
    realtime t0 = 0;
    adss_sequencer #(.CLK_HZ(HZ)) adss_sequencer_inst (.core_clk(core_clk), .srst(srst), .bus(bus),
        .rdata(rdata), .sample_data(sample_data), .sample_take(sample_take), .single_ended(single_ended),
        .conv_active(conv_active), .irq(irq));
    adss_conv_model adss_conv_model_inst (.core_clk(core_clk), .srst(srst), .sample_data(sample_data));
    // The clock runs at 10 MHz.
    always #50 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic print_verdict();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One strobe cycle, then an idle cycle, so the bus is never assigned twice in one step.
    task automatic op(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r, input logic [15:0] e);
        @(posedge core_clk);
        bus <= '{a, d, w, r};
        if (r) exp_q.push_back(e);
        @(posedge core_clk);
        bus <= '0;
    endtask
    // Waits for the end of a conversion under a bound, then lets the status settle.
    task automatic wait_take();
        int n;
        n = 0;
        while (sample_take !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 2000) errors++;
        repeat (2) @(posedge core_clk);
    endtask
    // Read data only stand in the cycle after the strobe, so the note is matched in mid-cycle there.
    always @(posedge core_clk) begin
        pend <= bus.rd;
        cyc <= cyc + 1;
        if (cyc > 6000) begin
            errors++;
            print_verdict();
        end
    end
    // The converter word and the conversion length are noted where the capture pulse stands.
    always @(negedge core_clk) begin
        if (pend) check(rdata, exp_q.pop_front());
        if (sample_take === 1'b1) begin
            last_res = sample_data;
            conv_len = int'(($realtime - t0 + 50) / 100);
        end
    end
    // Reset defaults, an unmapped place, every rate and input code, the interrupt, then continuous mode.
    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        op(`ADSS_OFF_CONFIG, 16'h0000, 1'b0, 1'b1, 16'h0583);
        op(4'h5, 16'hffff, 1'b1, 1'b0, 16'h0000);
        op(4'h5, 16'h0000, 1'b0, 1'b1, 16'h0000);
        op(`ADSS_OFF_IRQ_MASK, 16'h0001, 1'b1, 1'b0, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            lfsr_q = lfsr(lfsr_q);
            cfg = {1'b1, c[2:0], lfsr_q[2:0], 1'b1, c[2:0], 5'h03};
            op(`ADSS_OFF_CONFIG, cfg, 1'b1, 1'b0, 16'h0000);
            t0 = $realtime;
            op(`ADSS_OFF_CONFIG, 16'h0000, 1'b0, 1'b1, {1'b0, cfg[14:0]});
            op(`ADSS_OFF_RESULT, 16'h0000, 1'b0, 1'b1, last_res);
            wait_take();
            check(conv_len[15:0], 16'(HZ / SPS[c]));
            check({13'h0000, conv_active, irq, single_ended}, {15'h0001, c == 4 || c == 5});
            op(`ADSS_OFF_CONFIG, 16'h0000, 1'b0, 1'b1, cfg);
            op(`ADSS_OFF_IRQ_STATUS, 16'h0001, 1'b1, 1'b0, 16'h0000);
            @(negedge core_clk);
            check({15'h0000, irq}, 16'h0000);
        end
        op(`ADSS_OFF_SAMPLE, 16'h0000, 1'b0, 1'b1, 16'h0001);
        op(`ADSS_OFF_RESULT, 16'h0000, 1'b0, 1'b1, last_res);
        op(`ADSS_OFF_IRQ_MASK, 16'h0000, 1'b1, 1'b0, 16'h0000);
        // A second start lands while the first conversion runs, so both status bits set.
        op(`ADSS_OFF_CONFIG, 16'h85c3, 1'b1, 1'b0, 16'h0000);
        op(`ADSS_OFF_CONFIG, 16'h85c3, 1'b1, 1'b0, 16'h0000);
        wait_take();
        check({15'h0000, irq}, 16'h0000);
        op(`ADSS_OFF_IRQ_STATUS, 16'h0000, 1'b0, 1'b1, 16'h0003);
        op(`ADSS_OFF_IRQ_STATUS, 16'h0003, 1'b1, 1'b0, 16'h0000);
        op(`ADSS_OFF_IRQ_STATUS, 16'h0000, 1'b0, 1'b1, 16'h0000);
        op(`ADSS_OFF_CONFIG, 16'h84c3, 1'b1, 1'b0, 16'h0000);
        op(`ADSS_OFF_CONFIG, 16'h0000, 1'b0, 1'b1, 16'h04c3);
        wait_take();
        op(`ADSS_OFF_CONFIG, 16'h0000, 1'b0, 1'b1, 16'h04c3);
        repeat (3) @(posedge core_clk);
        print_verdict();
    end
endmodule
